/* hdl/control_instruction_unit_consts.svh */
// Opcodes, vectors, field positions and offsets of the control instruction unit.
`ifndef CONTROL_INSTRUCTION_UNIT_CONSTS_SVH
`define CONTROL_INSTRUCTION_UNIT_CONSTS_SVH

// Whole upper halfwords of the fixed-code control instructions.
`define HW_HALT          16'h0000
`define HW_WAIT          16'h0001
`define HW_NOP           16'h0002
`define HW_START_STOP    16'h000A
`define HW_SUPER_CALL    16'hC806
// Opcode (bits 0-5) and augment (bits 12-15) of the register-form instructions.
`define OPC_CONTROL      6'h00
`define AUG_EXEC_REG     4'h6
`define AUG_EXEC_RIGHT   4'h7
`define AUG_SET_MODE     4'h9
`define AUG_READ_STATUS  4'hB
// Opcodes of the memory-form instructions.
`define OPC_EXEC_MEM     6'h2A
`define OPC_CALL_MON     6'h0C
// Trap and interrupt vectors.
`define VEC_UNDEF        12'h194
`define VEC_PRIV         12'h198
`define VEC_BLOCK_TMO    12'h0E4
`define VEC_SUPER_CALL   12'h180
`define VEC_COPROC_END   12'h2E0
`define VEC_COPROC_START 12'h2E4
`define VEC_COPROC_STOP  12'h2F4
`define CALL_MON_LEVEL   7'h27
// Byte offsets of the context block words 1 to 5.
`define CTX_W1           24'h000000
`define CTX_W2           24'h000004
`define CTX_W3           24'h000008
`define CTX_W4           24'h00000C
`define CTX_W5           24'h000010
// Mode bits of the set-mode operand, counted from the least significant end.
`define MODE_BMT_BIT     17
`define MODE_PSDTRAP_BIT 16
`define MODE_SDW_BIT     12
// Status word reset value and the number of low bits kept by a status read.
`define STATUS_RESET     32'h00000000
`define STATUS_KEEP      8

`endif

/* hdl/control_instruction_unit_pkg.sv */
// Types of the control instruction unit.
`include "control_instruction_unit_consts.svh"
package control_instruction_unit_pkg;

    // Gray coded along the context-switch path.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_VEC   = 4'h1,
        ST_W1    = 4'h3,
        ST_W2    = 4'h2,
        ST_W5    = 4'h6,
        ST_R3    = 4'h7,
        ST_R4    = 4'h5,
        ST_LOAD  = 4'h4,
        ST_FETCH = 4'hC,
        ST_CHECK = 4'hD
    } state_e;

    typedef struct packed {
        state_e      state;
        logic        busy;
        logic        done;
        logic        trap;
        logic [11:0] trap_vec;
        logic [31:0] ir;
        logic        ir_load;
        logic        ir_half;
        logic [23:0] resume;
        logic        halted;
        logic        wait_st;
        logic        wait_ind;
        logic        irq_req;
        logic [6:0]  irq_level;
        logic [9:0]  irq_flags;
        logic [3:0]  sc_idx;
        logic [11:0] sc_call;
        logic        cc_we;
        logic [3:0]  cc;
        logic        bmt_en;
        logic        sdw_trap_en;
        logic        sdw_mode;
        logic [31:0] status;
        logic        rd_we;
        logic [31:0] rd_data;
        logic        start;
        logic        cp_done;
        logic        stopping;
        logic        sdw_load;
        logic [31:0] sdw_hi;
        logic [31:0] sdw_lo;
        logic [23:0] ctx;
        logic        mem_req;
        logic        mem_we;
        logic [23:0] mem_addr;
        logic [31:0] mem_wdata;
    } unit_s;

endpackage : control_instruction_unit_pkg

/* hdl/control_instruction_unit.sv */
// Control-class instruction execution unit for the CPU and the coprocessor.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module control_instruction_unit (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        coproc_role_in,
    input  wire logic        issue_in,
    input  wire logic [31:0] instr_in,
    input  wire logic [23:0] pc_in,
    input  wire logic [31:0] reg_data_in,
    input  wire logic [23:0] eff_in,
    input  wire logic        privileged_in,
    input  wire logic        ints_blocked_in,
    input  wire logic        sdw_jumper_in,
    input  wire logic        run_switch_in,
    input  wire logic        int_service_in,
    input  wire logic        target_unimpl_in,
    input  wire logic        target_sdw_only_in,
    input  wire logic        target_half_in,
    input  wire logic        err_valid_in,
    input  wire logic        err_ext_class_in,
    input  wire logic        err_int_proc_in,
    input  wire logic [29:0] err_flags_in,
    input  wire logic        coproc_start_in,
    input  wire logic        coproc_done_in,
    input  wire logic [31:0] sdw_hi_in,
    input  wire logic [31:0] sdw_lo_in,
    input  wire logic [31:0] unit_status_in,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in,
    output logic             busy_out,
    output logic             done_out,
    output logic             trap_out,
    output logic [11:0]      trap_vec_out,
    output logic [31:0]      ir_data_out,
    output logic             ir_load_out,
    output logic             ir_half_out,
    output logic [23:0]      resume_pc_out,
    output logic             halted_out,
    output logic             wait_ind_out,
    output logic             irq_req_out,
    output logic [6:0]       irq_level_out,
    output logic [9:0]       irq_flags_out,
    output logic [3:0]       sc_index_out,
    output logic [11:0]      sc_call_out,
    output logic             cc_write_out,
    output logic [3:0]       cc_out,
    output logic             bmt_enable_out,
    output logic             sdw_trap_enable_out,
    output logic             sdw_mode_out,
    output logic             rd_write_out,
    output logic [31:0]      rd_data_out,
    output logic             coproc_start_out,
    output logic             coproc_done_out,
    output logic             sdw_load_out,
    output logic [31:0]      sdw_hi_out,
    output logic [31:0]      sdw_lo_out,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic [23:0]      mem_addr_out,
    output logic [31:0]      mem_wdata_out
);

    control_instruction_unit_pkg::unit_s st_ff;
    control_instruction_unit_pkg::unit_s nxt_st;

    // Matches a register-form control instruction on opcode and augment.
    function automatic logic is_rr(input logic [31:0] w, input logic [3:0] aug);
        is_rr = (w[31:26] == `OPC_CONTROL) && (w[19:16] == aug);
    endfunction : is_rr

    // True for any of the three execute instructions.
    function automatic logic is_exec(input logic [31:0] w);
        is_exec = is_rr(w, `AUG_EXEC_REG) || is_rr(w, `AUG_EXEC_RIGHT) || (w[31:26] == `OPC_EXEC_MEM);
    endfunction : is_exec

    // Computes the next state; pulses fall back to zero every cycle.
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.done      = 1'b0;
        nxt_st.trap      = 1'b0;
        nxt_st.ir_load   = 1'b0;
        nxt_st.irq_req   = 1'b0;
        nxt_st.cc_we     = 1'b0;
        nxt_st.rd_we     = 1'b0;
        nxt_st.start     = 1'b0;
        nxt_st.cp_done   = 1'b0;
        nxt_st.sdw_load  = 1'b0;
        nxt_st.wait_ind  = st_ff.wait_st & ~int_service_in;
        case (st_ff.state)
            control_instruction_unit_pkg::ST_IDLE:
            begin
                if (run_switch_in)
                begin
                    nxt_st.halted  = 1'b0;
                    nxt_st.wait_st = 1'b0;
                end
                if (coproc_role_in && coproc_start_in)
                begin
                    nxt_st.stopping = 1'b0;
                    nxt_st.state    = control_instruction_unit_pkg::ST_VEC;
                end
                else if (!coproc_role_in && coproc_done_in)
                begin
                    nxt_st.trap     = 1'b1;
                    nxt_st.trap_vec = `VEC_COPROC_END;
                end
                else if (issue_in && !st_ff.halted && !st_ff.wait_st)
                begin
                    nxt_st.done = 1'b1;
                    if (is_rr(instr_in, `AUG_EXEC_REG))
                    begin
                        nxt_st.ir     = reg_data_in;
                        nxt_st.resume = pc_in + 24'h000002;
                        nxt_st.done   = 1'b0;
                        nxt_st.state  = control_instruction_unit_pkg::ST_CHECK;
                    end
                    else if (is_rr(instr_in, `AUG_EXEC_RIGHT))
                    begin
                        nxt_st.ir     = {reg_data_in[15:0], 16'h0000};
                        nxt_st.resume = pc_in + 24'h000002;
                        nxt_st.done   = 1'b0;
                        nxt_st.state  = control_instruction_unit_pkg::ST_CHECK;
                    end
                    else if (instr_in[31:26] == `OPC_EXEC_MEM)
                    begin
                        nxt_st.ir[1]  = eff_in[1];
                        nxt_st.resume = pc_in + 24'h000004;
                        nxt_st.done   = 1'b0;
                        nxt_st.state  = control_instruction_unit_pkg::ST_FETCH;
                    end
                    else if (instr_in[31:16] == `HW_HALT)
                    begin
                        if (privileged_in)
                        begin
                            nxt_st.halted = 1'b1;
                        end
                        else
                        begin
                            nxt_st.trap     = 1'b1;
                            nxt_st.trap_vec = `VEC_PRIV;
                        end
                    end
                    else if (instr_in[31:16] == `HW_WAIT)
                    begin
                        if (ints_blocked_in)
                        begin
                            nxt_st.trap     = 1'b1;
                            nxt_st.trap_vec = `VEC_BLOCK_TMO;
                        end
                        else
                        begin
                            nxt_st.wait_st  = 1'b1;
                            nxt_st.wait_ind = ~int_service_in;
                        end
                    end
                    else if (instr_in[31:16] == `HW_START_STOP)
                    begin
                        if (coproc_role_in)
                        begin
                            nxt_st.done     = 1'b0;
                            nxt_st.stopping = 1'b1;
                            nxt_st.state    = control_instruction_unit_pkg::ST_VEC;
                        end
                        else
                        begin
                            nxt_st.start = 1'b1;
                        end
                    end
                    else if (instr_in[31:16] == `HW_SUPER_CALL)
                    begin
                        nxt_st.trap = 1'b1;
                        if (st_ff.sdw_mode)
                        begin
                            nxt_st.trap_vec = `VEC_SUPER_CALL;
                            nxt_st.sc_idx   = instr_in[15:12];
                            nxt_st.sc_call  = instr_in[11:0];
                            nxt_st.cc_we    = 1'b1;
                            nxt_st.cc       = 4'h0;
                        end
                        else
                        begin
                            nxt_st.trap_vec = `VEC_UNDEF;
                        end
                    end
                    else if (instr_in[31:26] == `OPC_CALL_MON)
                    begin
                        nxt_st.irq_req   = 1'b1;
                        nxt_st.irq_level = `CALL_MON_LEVEL;
                        nxt_st.irq_flags = instr_in[25:16];
                    end
                    else if (is_rr(instr_in, `AUG_SET_MODE))
                    begin
                        if (sdw_jumper_in)
                        begin
                            nxt_st.bmt_en      = reg_data_in[`MODE_BMT_BIT];
                            nxt_st.sdw_trap_en = reg_data_in[`MODE_PSDTRAP_BIT];
                            nxt_st.sdw_mode    = reg_data_in[`MODE_SDW_BIT];
                        end
                        else
                        begin
                            nxt_st.trap     = 1'b1;
                            nxt_st.trap_vec = `VEC_UNDEF;
                        end
                    end
                    else if (is_rr(instr_in, `AUG_READ_STATUS))
                    begin
                        nxt_st.rd_we   = 1'b1;
                        nxt_st.rd_data = st_ff.status;
                        nxt_st.status[31:`STATUS_KEEP] = '0;
                        nxt_st.cc_we   = 1'b1;
                        nxt_st.cc      = {1'b0, st_ff.sdw_mode, ints_blocked_in, st_ff.status[31:8] == 24'h000000};
                    end
                    // The no-op and unknown codes simply complete here.
                end
            end
            control_instruction_unit_pkg::ST_FETCH:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.ir    = st_ff.ir[1] ? {mem_rdata_in[15:0], 16'h0000} : mem_rdata_in;
                    nxt_st.state = control_instruction_unit_pkg::ST_CHECK;
                end
            end
            control_instruction_unit_pkg::ST_CHECK:
            begin
                nxt_st.state = control_instruction_unit_pkg::ST_IDLE;
                nxt_st.done  = 1'b1;
                if (is_exec(st_ff.ir) || target_unimpl_in || target_sdw_only_in)
                begin
                    nxt_st.trap     = 1'b1;
                    nxt_st.trap_vec = `VEC_UNDEF;
                end
                else
                begin
                    nxt_st.ir_load = 1'b1;
                    nxt_st.ir_half = target_half_in;
                    if (target_half_in)
                    begin
                        nxt_st.ir[15:0] = 16'h0000;
                    end
                end
            end
            control_instruction_unit_pkg::ST_VEC:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.ctx    = mem_rdata_in[23:0];
                    nxt_st.sdw_hi = sdw_hi_in;
                    nxt_st.sdw_lo = sdw_lo_in;
                    nxt_st.state  = control_instruction_unit_pkg::ST_W1;
                end
            end
            control_instruction_unit_pkg::ST_W1:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.state = control_instruction_unit_pkg::ST_W2;
                end
            end
            control_instruction_unit_pkg::ST_W2:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.state = control_instruction_unit_pkg::ST_W5;
                end
            end
            control_instruction_unit_pkg::ST_W5:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.cp_done = st_ff.stopping;
                    nxt_st.state   = control_instruction_unit_pkg::ST_R3;
                end
            end
            control_instruction_unit_pkg::ST_R3:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.sdw_hi = mem_rdata_in;
                    nxt_st.state  = control_instruction_unit_pkg::ST_R4;
                end
            end
            control_instruction_unit_pkg::ST_R4:
            begin
                if (mem_ack_in)
                begin
                    nxt_st.sdw_lo = mem_rdata_in;
                    nxt_st.state  = control_instruction_unit_pkg::ST_LOAD;
                end
            end
            control_instruction_unit_pkg::ST_LOAD:
            begin
                nxt_st.sdw_load = 1'b1;
                nxt_st.done     = st_ff.stopping;
                nxt_st.state    = control_instruction_unit_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_st.state = control_instruction_unit_pkg::ST_IDLE;
            end
        endcase
        // Error events load the class bits and set the rest; a set beats a read clear.
        if (err_valid_in)
        begin
            nxt_st.status[31] = err_ext_class_in;
            nxt_st.status[30] = err_int_proc_in;
            nxt_st.status[29:0] = nxt_st.status[29:0] | err_flags_in;
        end
        // Memory request follows the state it is entering.
        nxt_st.mem_req   = 1'b1;
        nxt_st.mem_we    = 1'b0;
        nxt_st.mem_wdata = 32'h00000000;
        case (nxt_st.state)
            control_instruction_unit_pkg::ST_FETCH:
                nxt_st.mem_addr = {eff_in[23:2], 2'b00};
            control_instruction_unit_pkg::ST_VEC:
                nxt_st.mem_addr = {12'h000, nxt_st.stopping ? `VEC_COPROC_STOP : `VEC_COPROC_START};
            control_instruction_unit_pkg::ST_W1:
            begin
                nxt_st.mem_we    = 1'b1;
                nxt_st.mem_addr  = nxt_st.ctx + `CTX_W1;
                nxt_st.mem_wdata = nxt_st.sdw_hi;
            end
            control_instruction_unit_pkg::ST_W2:
            begin
                nxt_st.mem_we    = 1'b1;
                nxt_st.mem_addr  = nxt_st.ctx + `CTX_W2;
                nxt_st.mem_wdata = nxt_st.sdw_lo;
            end
            control_instruction_unit_pkg::ST_W5:
            begin
                nxt_st.mem_we    = 1'b1;
                nxt_st.mem_addr  = nxt_st.ctx + `CTX_W5;
                nxt_st.mem_wdata = unit_status_in;
            end
            control_instruction_unit_pkg::ST_R3:
                nxt_st.mem_addr = nxt_st.ctx + `CTX_W3;
            control_instruction_unit_pkg::ST_R4:
                nxt_st.mem_addr = nxt_st.ctx + `CTX_W4;
            default:
                nxt_st.mem_req = 1'b0;
        endcase
        nxt_st.busy = (nxt_st.state != control_instruction_unit_pkg::ST_IDLE) | nxt_st.halted | nxt_st.wait_st;
    end

    // Registers the whole state; reset leaves mode bits and status cleared.
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Every output is a field of the registered state.
    assign busy_out            = st_ff.busy;
    assign done_out            = st_ff.done;
    assign trap_out            = st_ff.trap;
    assign trap_vec_out        = st_ff.trap_vec;
    assign ir_data_out         = st_ff.ir;
    assign ir_load_out         = st_ff.ir_load;
    assign ir_half_out         = st_ff.ir_half;
    assign resume_pc_out       = st_ff.resume;
    assign halted_out          = st_ff.halted;
    assign wait_ind_out        = st_ff.wait_ind;
    assign irq_req_out         = st_ff.irq_req;
    assign irq_level_out       = st_ff.irq_level;
    assign irq_flags_out       = st_ff.irq_flags;
    assign sc_index_out        = st_ff.sc_idx;
    assign sc_call_out         = st_ff.sc_call;
    assign cc_write_out        = st_ff.cc_we;
    assign cc_out              = st_ff.cc;
    assign bmt_enable_out      = st_ff.bmt_en;
    assign sdw_trap_enable_out = st_ff.sdw_trap_en;
    assign sdw_mode_out        = st_ff.sdw_mode;
    assign rd_write_out        = st_ff.rd_we;
    assign rd_data_out         = st_ff.rd_data;
    assign coproc_start_out    = st_ff.start;
    assign coproc_done_out     = st_ff.cp_done;
    assign sdw_load_out        = st_ff.sdw_load;
    assign sdw_hi_out          = st_ff.sdw_hi;
    assign sdw_lo_out          = st_ff.sdw_lo;
    assign mem_req_out         = st_ff.mem_req;
    assign mem_we_out          = st_ff.mem_we;
    assign mem_addr_out        = st_ff.mem_addr;
    assign mem_wdata_out       = st_ff.mem_wdata;

endmodule : control_instruction_unit

`default_nettype wire

/* test/control_instruction_unit_asserts.sv */
// Checker of the control instruction unit's port behaviour.
`timescale 1ns/1ps
`default_nettype none
module control_instruction_unit_asserts (
    input wire logic        clk_in, reset_n_in, issue_in, ints_blocked_in, run_switch_in,
    input wire logic        coproc_start_in, coproc_done_in, busy_out, done_out, trap_out,
    input wire logic        ir_load_out, halted_out, wait_ind_out, irq_req_out, cc_write_out,
    input wire logic        sdw_mode_out, coproc_done_out, sdw_load_out, mem_req_out, mem_we_out,
    input wire logic [31:0] instr_in, reg_data_in, ir_data_out,
    input wire logic [11:0] trap_vec_out,
    input wire logic [6:0]  irq_level_out
);
    // An instruction is taken only when nothing else holds the unit.
    wire logic take = issue_in && !busy_out && !halted_out && !wait_ind_out && !coproc_start_in && !coproc_done_in;
    wire logic [15:0] hw = instr_in[31:16];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_XR_END: assert property (take && hw == 16'h6 |=> busy_out ##1 done_out && (ir_load_out || trap_out))
        else $error("register execute unfinished");
    AST_XRR_IR: assert property (take && hw == 16'h7
        |=> ir_data_out == {$past(reg_data_in[15:0]), 16'h0000}) else $error("right half misplaced");
    AST_WAIT_BLK: assert property (take && hw == 16'h1 && ints_blocked_in
        |=> trap_out && trap_vec_out == 12'h0E4) else $error("blocked wait no trap");
    AST_NOP: assert property (take && hw == 16'h2 |=> done_out && !cc_write_out && !trap_out)
        else $error("no-op changed state");
    AST_IRQ_LEVEL: assert property (irq_req_out |-> irq_level_out == 7'h27)
        else $error("call monitor level wrong");
    AST_SC_MODE: assert property (take && hw == 16'hC806 && !sdw_mode_out
        |=> trap_out && trap_vec_out == 12'h194) else $error("supervisor call outside doubleword mode");
    AST_HALT_HOLD: assert property (halted_out && !run_switch_in |=> halted_out)
        else $error("halt left early");
    AST_DONE_ORDER: assert property (coproc_done_out |-> mem_req_out && !mem_we_out && !sdw_load_out)
        else $error("done out of order");
    COV_DONE: cover property (coproc_done_out);
    COV_LOAD: cover property (sdw_load_out);
    COV_WAIT: cover property (take && hw == 16'h0001 && !ints_blocked_in);
endmodule : control_instruction_unit_asserts
`default_nettype wire

/* test/ctl_mem_model.sv */
// Memory model of the far side, answering each request after a set lag.
`timescale 1ns/1ps
`default_nettype none
module ctl_mem_model (
    input wire logic        clk_in, req_in, we_in,
    input wire logic [23:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0]  lag_in,
    output logic            ack_out,
    output logic [31:0]     rdata_out
);
    logic [31:0] mem [0:255];
    logic [3:0]  cnt;
    // Vectors, context blocks and an execute target.
    initial
    begin
        {ack_out, cnt, rdata_out} = '0;
        {mem[8'hB9], mem[8'hBD]} = {32'h0000_0140, 32'h0000_0100};
        {mem[8'h42], mem[8'h43], mem[8'h52], mem[8'h53]} = {32'h1111_2222, 32'h3333_4444, 32'h5555_6666, 32'h7777_8888};
        mem[8'h80] = 32'h1234_0002;
    end
    // Read data toggles off the acknowledge so stale data never passes as valid.
    always @(posedge clk_in)
    begin
        ack_out <= 1'h0;
        rdata_out <= ~rdata_out;
        cnt <= req_in ? cnt + 4'h1 : 4'h0;
        if (req_in && !ack_out && cnt >= lag_in)
        begin
            {ack_out, cnt} <= {1'h1, 4'h0};
            rdata_out <= mem[addr_in[9:2]];
            if (we_in)
                mem[addr_in[9:2]] <= wdata_in;
        end
    end
endmodule : ctl_mem_model
`default_nettype wire

/* test/tb_control_instruction_unit.sv */
// Self-checking testbench of the control instruction unit.
`timescale 1ns/1ps
`default_nettype none
module tb_control_instruction_unit;
    logic clk_in = 0, reset_n_in = 0, coproc_role_in = 0, issue_in = 0, privileged_in = 1, ints_blocked_in = 0;
    logic sdw_jumper_in = 1, run_switch_in = 0, int_service_in = 0, target_unimpl_in = 0, target_sdw_only_in = 0;
    logic target_half_in = 0, err_valid_in = 0, err_ext_class_in = 0, err_int_proc_in = 0, coproc_start_in = 0;
    logic coproc_done_in = 0, mem_ack_in, busy_out, done_out, trap_out, ir_load_out, ir_half_out, halted_out;
    logic wait_ind_out, irq_req_out, cc_write_out, bmt_enable_out, sdw_trap_enable_out, sdw_mode_out, rd_write_out;
    logic coproc_start_out, coproc_done_out, sdw_load_out, mem_req_out, mem_we_out;
    logic [31:0] instr_in = 0, reg_data_in = 0, sdw_hi_in = 32'h0A0B_0C0D, sdw_lo_in = 0, unit_status_in = 32'h00C0_FFEE;
    logic [31:0] mem_rdata_in, ir_data_out, rd_data_out, sdw_hi_out, sdw_lo_out, mem_wdata_out;
    logic [23:0] pc_in = 24'h001000, eff_in = 0, resume_pc_out, mem_addr_out;
    logic [29:0] err_flags_in = 0;
    logic [11:0] trap_vec_out, sc_call_out, tv;
    logic [9:0]  irq_flags_out;
    logic [6:0]  irq_level_out;
    logic [3:0]  sc_index_out, cc_out, lag = 0;
    int          errors = 0, check_count = 0;
    control_instruction_unit dut_u (.*);
    ctl_mem_model mem_u (.clk_in(clk_in), .req_in(mem_req_out), .we_in(mem_we_out), .addr_in(mem_addr_out),
        .wdata_in(mem_wdata_out), .lag_in(lag), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
    always #20 clk_in = ~clk_in;
    task automatic chk(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Issues one instruction and waits for its result, keeping the trap vector seen.
    task automatic op(input logic [31:0] i, r);
        tv = 12'hFFF;
        {instr_in, reg_data_in, issue_in} <= {i, r, 1'h1};
        @(posedge clk_in);
        issue_in <= 1'h0;
        for (int k = 0; k < 40; k++)
        begin
            #1;
            if (trap_out) tv = trap_vec_out;
            if (done_out || trap_out || irq_req_out || rd_write_out) break;
            @(posedge clk_in);
        end
    endtask : op
    task automatic pulse(input int n);
        {run_switch_in, err_valid_in, coproc_start_in} <= 3'h4 >> n;
        @(posedge clk_in);
        {run_switch_in, err_valid_in, coproc_start_in} <= 3'h0;
        @(posedge clk_in) #1;
    endtask : pulse
    task automatic t_exec;
        op(32'h0007_0000, 32'h1234_0002);
        chk(ir_data_out, 32'h0002_0000);
        chk(resume_pc_out, 24'h001002);
        target_unimpl_in <= 1'h1;
        op(32'h0006_0000, 32'h0006_0000);
        chk(tv, 12'h194);
        {target_unimpl_in, eff_in} <= {1'h0, 24'h000202};
        op(32'hA800_0000, 0);
        chk(ir_data_out, 32'h0002_0000);
    endtask : t_exec
    task automatic t_wait_halt;
        ints_blocked_in <= 1'h1;
        op(32'h0001_0000, 0);
        chk(tv, 12'h0E4);
        ints_blocked_in <= 1'h0;
        op(32'h0001_0000, 0);
        chk(wait_ind_out, 1'h1);
        op(32'h0002_0000, 0);
        chk(tv, 12'hFFF);
        pulse(0);
        op(32'h0000_0000, 0);
        chk(halted_out, 1'h1);
        pulse(0);
        chk(halted_out, 1'h0);
    endtask : t_wait_halt
    task automatic t_modes;
        op(32'hC806_5ABC, 0);
        chk(tv, 12'h194);
        op(32'h0009_0000, 32'h0003_1000);
        chk({bmt_enable_out, sdw_trap_enable_out, sdw_mode_out}, 3'h7);
        op(32'hC806_5ABC, 0);
        chk({tv, sc_index_out, sc_call_out, cc_out}, {12'h180, 4'h5, 12'hABC, 4'h0});
        sdw_jumper_in <= 1'h0;
        op(32'h0009_0000, 0);
        chk(tv, 12'h194);
        op(32'h32A5_0000, 0);
        chk({irq_level_out, irq_flags_out}, {7'h27, 10'h2A5});
    endtask : t_modes
    task automatic t_status;
        {err_ext_class_in, err_int_proc_in} <= 2'h3;
        pulse(1);
        op(32'h000B_0000, 0);
        chk(rd_data_out[31:30], 2'h3);
        op(32'h000B_0000, 0);
        chk(rd_data_out[31:8], 24'h0);
    endtask : t_status
    task automatic t_coproc;
        {coproc_role_in, lag} <= {1'h1, 4'h2};
        op(32'h000A_0000, 0);
        chk(sdw_hi_out, 32'h1111_2222);
        chk(mem_u.mem[8'h40], sdw_hi_in);
        chk(mem_u.mem[8'h44], unit_status_in);
        pulse(2);
        for (int k = 0; k < 40 && sdw_load_out !== 1'h1; k++) @(posedge clk_in) #1;
        chk(sdw_hi_out, 32'h5555_6666);
    endtask : t_coproc
    task automatic wrap_up;
        if (errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    // Main sequence after a two-cycle reset.
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'h1;
        @(posedge clk_in);
        t_exec;
        t_wait_halt;
        t_modes;
        t_status;
        t_coproc;
        wrap_up;
    end
    // Watchdog of 2000 cycles.
    initial
    begin
        #80000;
        errors++;
        wrap_up;
    end
endmodule : tb_control_instruction_unit
bind control_instruction_unit control_instruction_unit_asserts ast_u (.*);
`default_nettype wire
